/* hdl/dpsd_builder.sv */
// DP slave diagnostic block builder and octet serializer
// Operation
// - Extended content fills octets seven to thirty-two, block never over 32 octets.
// - Octet 1 bit 7 set when locked by another master.
// - Octet 1 bit 6 set when last parameter request invalid.
// - Octet 1 bit 4 set when last request unsupported.
// - Octet 1 bit 3 set when extended content is present.
// - Octet 1 bit 2 set on configuration mismatch.
// - Octet 1 bit 1 set while not ready for data exchange.
// - Octet 2 bit 5 set once sync command received.
// - Octet 2 bit 4 set once freeze command received.
// - Octet 2 bit 3 set while watchdog active.
// - Octet 2 bit 1 asks master to fetch diagnostics again.
// - Octet 2 bit 0 requests re-parameterization.
// - Octet 3 bit 7 flags extended overflow; bits 0-6 reserved.
// - Octet 4 holds parameterizing master address.
// - Octets 5 and 6 hold the 16-bit identification number.
`timescale 1ns/1ps
module dpsd_builder (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Slave state
  input wire logic other_master_lock,
  input wire logic prm_fault,
  input wire logic not_supported,
  input wire logic cfg_fault,
  input wire logic station_not_ready,
  input wire logic sync_cmd,
  input wire logic freeze_cmd,
  input wire logic unsync_cmd,
  input wire logic unfreeze_cmd,
  input wire logic wdog_active,
  input wire logic fetch_again,
  input wire logic prm_request,
  input wire logic ext_overflow,
  input wire logic master_addr_load,
  input wire logic [7:0] master_addr,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Octet stream toward the bus
  input wire logic diag_start,
  input wire logic octet_ready,
  output logic octet_valid,
  output logic [7:0] octet_data,
  output logic octet_last,
  output logic [5:0] diag_len
);
  import dpsd_pkg::*;

  // Register map: 0x00..0x19 extended octets, 0x1a ext length, 0x1b/0x1c ident hi/lo,
  // 0x20..0x3f read-only view of the whole block
  localparam logic [5:0] REG_EXT_LEN = 6'h1a;
  localparam logic [5:0] REG_IDENT_HI = 6'h1b;
  localparam logic [5:0] REG_IDENT_LO = 6'h1c;
  localparam logic [5:0] REG_VIEW = 6'h20;

  logic [7:0] ext_mem_r [DPSD_EXT_MAX];
  logic [4:0] ext_len_r, ext_len_nxt;
  logic [15:0] ident_r, ident_nxt;
  logic [7:0] maddr_r, maddr_nxt;
  logic sync_r, sync_nxt, freeze_r, freeze_nxt;
  logic [7:0] st1, st2, st3;
  logic [7:0] block [DPSD_MAX_LEN];
  dpsd_state_e state_r, state_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic [7:0] rdata_nxt;

  // Status octets are assembled live so a poll always sees present state
  always_comb begin
    st1 = DPSD_BYTE_ZERO;
    st1[S1_OTHER_MASTER] = other_master_lock;
    st1[S1_PRM_FAULT] = prm_fault;
    st1[S1_NOT_SUPP] = not_supported;
    st1[S1_EXT_PRESENT] = (ext_len_r != 5'h00);
    st1[S1_CFG_FAULT] = cfg_fault;
    st1[S1_NOT_READY] = station_not_ready;
    // Bits 5 and 0 belong to the master's stored copy
    st1[S1_BAD_RESP] = 1'b0;
    st1[S1_NO_STATION] = 1'b0;
    st2 = DPSD_BYTE_ZERO;
    st2[S2_INACTIVE] = 1'b0;
    st2[S2_SYNC] = sync_r;
    st2[S2_FREEZE] = freeze_r;
    st2[S2_WDOG] = wdog_active;
    st2[S2_FETCH_AGAIN] = fetch_again;
    st2[S2_PRM_REQ] = prm_request;
    st3 = DPSD_BYTE_ZERO;
    st3[S3_OVERFLOW] = ext_overflow;
  end

  // Block image in transmit order
  always_comb begin
    block[0] = st1;
    block[1] = st2;
    block[2] = st3;
    block[3] = maddr_r;
    block[4] = ident_r[15:8];
    block[5] = ident_r[7:0];
    for (int i = 0; i < DPSD_EXT_MAX; i++) begin
      block[DPSD_HDR_LEN + i] = ext_mem_r[i];
    end
  end

  assign diag_len = DPSD_HDR_LEN6 + {1'b0, ext_len_r};

  // Sync and freeze modes stick until cancelled; set wins over cancel
  always_comb begin
    sync_nxt = sync_r;
    freeze_nxt = freeze_r;
    if (unsync_cmd) sync_nxt = 1'b0;
    if (sync_cmd) sync_nxt = 1'b1;
    if (unfreeze_cmd) freeze_nxt = 1'b0;
    if (freeze_cmd) freeze_nxt = 1'b1;
    maddr_nxt = master_addr_load ? master_addr : maddr_r;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_r <= 1'b0;
      freeze_r <= 1'b0;
      maddr_r <= DPSD_ADDR_RESET;
    end else begin
      sync_r <= sync_nxt;
      freeze_r <= freeze_nxt;
      maddr_r <= maddr_nxt;
    end
  end

  // Register writes; length is clamped so the block stays within 32 octets
  always_comb begin
    ext_len_nxt = ext_len_r;
    ident_nxt = ident_r;
    if (reg_wr && reg_addr == REG_EXT_LEN) begin
      ext_len_nxt = (reg_wdata > {3'b000, DPSD_EXT_MAX5}) ? DPSD_EXT_MAX5 : reg_wdata[4:0];
    end
    if (reg_wr && reg_addr == REG_IDENT_HI) ident_nxt[15:8] = reg_wdata;
    if (reg_wr && reg_addr == REG_IDENT_LO) ident_nxt[7:0] = reg_wdata;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ext_len_r <= 5'h00;
      ident_r <= DPSD_IDENT_DEFAULT;
    end else begin
      ext_len_r <= ext_len_nxt;
      ident_r <= ident_nxt;
    end
  end

  generate
    for (genvar g = 0; g < DPSD_EXT_MAX; g++) begin : g_ext
      logic [7:0] ext_nxt;
      always_comb begin
        ext_nxt = ext_mem_r[g];
        if (reg_wr && reg_addr == 6'(g)) ext_nxt = reg_wdata;
      end
      always_ff @(posedge clk) begin
        if (reset) ext_mem_r[g] <= DPSD_BYTE_ZERO;
        else ext_mem_r[g] <= ext_nxt;
      end
    end
  endgenerate

  // Reads: unmapped addresses return zero
  always_comb begin
    rdata_nxt = DPSD_BYTE_ZERO;
    if (reg_rd) begin
      if (reg_addr >= REG_VIEW) rdata_nxt = block[reg_addr[4:0]];
      else if (reg_addr < REG_EXT_LEN) rdata_nxt = ext_mem_r[reg_addr[4:0]];
      else if (reg_addr == REG_EXT_LEN) rdata_nxt = {3'b000, ext_len_r};
      else if (reg_addr == REG_IDENT_HI) rdata_nxt = ident_r[15:8];
      else if (reg_addr == REG_IDENT_LO) rdata_nxt = ident_r[7:0];
      else rdata_nxt = DPSD_BYTE_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) reg_rdata <= DPSD_BYTE_ZERO;
    else reg_rdata <= rdata_nxt;
  end

  // Serializer: octet_data is registered, valid follows state
  logic [7:0] odata_r, odata_nxt;
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    odata_nxt = odata_r;
    case (state_r)
      DPSD_IDLE: begin
        if (diag_start) begin
          state_nxt = DPSD_SEND;
          idx_nxt = 6'h00;
          odata_nxt = block[0];
        end
      end
      DPSD_SEND: begin
        if (octet_ready) begin
          if (idx_r + 6'h01 >= diag_len) begin
            state_nxt = DPSD_IDLE;
            idx_nxt = 6'h00;
          end else begin
            idx_nxt = idx_r + 6'h01;
            odata_nxt = block[5'(idx_r + 6'h01)];
          end
        end
      end
      default: begin
        state_nxt = DPSD_IDLE;
        idx_nxt = 6'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= DPSD_IDLE;
      idx_r <= 6'h00;
      odata_r <= DPSD_BYTE_ZERO;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      odata_r <= odata_nxt;
    end
  end

  assign octet_valid = (state_r == DPSD_SEND);
  assign octet_data = odata_r;
  assign octet_last = octet_valid && (idx_r + 6'h01 >= diag_len);

  // Assertions
  a_len_bound: assert property (@(posedge clk) disable iff (reset)
    diag_len <= DPSD_MAX_LEN6 && diag_len >= DPSD_HDR_LEN6)
    else $error("diagnostic length out of range");
  a_lock_bit: assert property (@(posedge clk) disable iff (reset)
    block[0][S1_OTHER_MASTER] == other_master_lock)
    else $error("lock bit mismatch");
  a_prm_fault: assert property (@(posedge clk) disable iff (reset)
    block[0][S1_PRM_FAULT] == prm_fault)
    else $error("parameter fault bit mismatch");
  a_ext_flag: assert property (@(posedge clk) disable iff (reset)
    block[0][S1_EXT_PRESENT] == (diag_len > DPSD_HDR_LEN6))
    else $error("extension flag disagrees with length");
  a_sync_sticky: assert property (@(posedge clk) disable iff (reset)
    sync_cmd |=> block[1][S2_SYNC])
    else $error("sync mode not flagged");
  a_freeze_hold: assert property (@(posedge clk) disable iff (reset)
    freeze_cmd ##1 (!unfreeze_cmd)[*2] |=> block[1][S2_FREEZE])
    else $error("freeze mode lost");
  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    block[1][6] == 1'b0 && block[1][2] == 1'b0 && block[2][6:0] == 7'h00)
    else $error("reserved bit set");
  a_addr_load: assert property (@(posedge clk) disable iff (reset)
    master_addr_load |=> block[3] == $past(master_addr))
    else $error("master address not loaded");
  sequence s_start;
    state_r == DPSD_IDLE && diag_start;
  endsequence
  sequence s_first_octets;
    octet_valid && octet_data == $past(block[0], 1);
  endsequence
  a_first_octet: assert property (@(posedge clk) disable iff (reset)
    s_start |=> s_first_octets)
    else $error("first octet not status octet 1");
  // Octets are picked at the accepting edge, so compare with the value seen there
  a_ident_order: assert property (@(posedge clk) disable iff (reset)
    octet_valid && octet_ready && idx_r == 6'h03 |=> octet_data == $past(ident_r[15:8]))
    else $error("ident high octet not fifth");
  a_ident_low: assert property (@(posedge clk) disable iff (reset)
    octet_valid && octet_ready && idx_r == 6'h04 |=> octet_data == $past(ident_r[7:0]))
    else $error("ident low octet not sixth");
  a_ext_clamp: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == REG_EXT_LEN && reg_wdata > {3'b000, DPSD_EXT_MAX5} |=>
    diag_len == DPSD_MAX_LEN6)
    else $error("extended length not clamped");
  a_stream_end: assert property (@(posedge clk) disable iff (reset)
    octet_valid && octet_ready && octet_last |=> !octet_valid)
    else $error("stream runs past last octet");
  a_sync_clear: assert property (@(posedge clk) disable iff (reset)
    unsync_cmd && !sync_cmd |=> !block[1][S2_SYNC])
    else $error("sync mode not cancelled");
  a_freeze_clear: assert property (@(posedge clk) disable iff (reset)
    unfreeze_cmd && !freeze_cmd |=> !block[1][S2_FREEZE])
    else $error("freeze mode not cancelled");
  a_addr_hold: assert property (@(posedge clk) disable iff (reset)
    !master_addr_load |=> block[3] == $past(block[3]))
    else $error("master address changed without load");
  a_second_octet: assert property (@(posedge clk) disable iff (reset)
    octet_valid && octet_ready && idx_r == 6'h00 |=> octet_data == $past(block[1]))
    else $error("second octet not status octet 2");
  a_stream_hold: assert property (@(posedge clk) disable iff (reset)
    octet_valid && !octet_ready |=> octet_valid && $stable(octet_data))
    else $error("octet dropped while stalled");
  a_stream_busy: assert property (@(posedge clk) disable iff (reset)
    octet_valid && !(octet_ready && octet_last) |=> octet_valid)
    else $error("stream ended early");
endmodule : dpsd_builder

/* hdl/dpsd_pkg.sv */
// Package for the DP slave diagnostic block builder
package dpsd_pkg;
  // Block geometry
  localparam int unsigned DPSD_HDR_LEN = 6;
  localparam int unsigned DPSD_MAX_LEN = 32;
  localparam int unsigned DPSD_EXT_MAX = 26;
  localparam logic [5:0] DPSD_HDR_LEN6 = 6'h06;
  localparam logic [5:0] DPSD_MAX_LEN6 = 6'h20;
  localparam logic [4:0] DPSD_EXT_MAX5 = 5'h1a;
  // Octet 1 bit positions
  localparam int unsigned S1_OTHER_MASTER = 7;
  localparam int unsigned S1_PRM_FAULT = 6;
  localparam int unsigned S1_BAD_RESP = 5;
  localparam int unsigned S1_NOT_SUPP = 4;
  localparam int unsigned S1_EXT_PRESENT = 3;
  localparam int unsigned S1_CFG_FAULT = 2;
  localparam int unsigned S1_NOT_READY = 1;
  localparam int unsigned S1_NO_STATION = 0;
  // Octet 2 bit positions
  localparam int unsigned S2_INACTIVE = 7;
  localparam int unsigned S2_SYNC = 5;
  localparam int unsigned S2_FREEZE = 4;
  localparam int unsigned S2_WDOG = 3;
  localparam int unsigned S2_FETCH_AGAIN = 1;
  localparam int unsigned S2_PRM_REQ = 0;
  // Octet 3 bit position
  localparam int unsigned S3_OVERFLOW = 7;
  // Identification number, value arbitrary
  localparam logic [15:0] DPSD_IDENT_DEFAULT = 16'h5a3c;
  // Reset values
  localparam logic [7:0] DPSD_ADDR_RESET = 8'hff;
  localparam logic [7:0] DPSD_BYTE_ZERO = 8'h00;
  // Serializer states
  typedef enum logic [1:0] {
    DPSD_IDLE = 2'b00,
    DPSD_SEND = 2'b01
  } dpsd_state_e;
endpackage : dpsd_pkg

/* tb/dpsd_builder_bench.sv */
// Self-checking bench for the diagnostic block builder
`timescale 1ns/1ps
module dpsd_builder_bench;
  import dpsd_pkg::*;
  logic clk = 0, reset = 1, lock = 0, prm = 0, nsup = 0, cfg = 0, nrdy = 0, sync = 0, frz = 0;
  logic usy = 0, ufz = 0, wd = 0, fa = 0, preq = 0, ovf = 0, ald = 0, rwr = 0, rrd = 0;
  logic start = 0, slow = 0, ordy, oval, olast, rd_d = 0, sy = 0, fz = 0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, odat, st1, st2;
  logic [15:0] idn = DPSD_IDENT_DEFAULT;
  logic [7:0] ext[26];
  logic [5:0] radr = 6'h00, dlen;
  logic [8:0] oq[$];
  logic [7:0] rq[$];
  int seed = 75234, num_errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  dpsd_builder dut (.clk(clk), .reset(reset), .other_master_lock(lock), .prm_fault(prm),
    .not_supported(nsup), .cfg_fault(cfg), .station_not_ready(nrdy), .sync_cmd(sync),
    .freeze_cmd(frz), .unsync_cmd(usy), .unfreeze_cmd(ufz), .wdog_active(wd),
    .fetch_again(fa), .prm_request(preq), .ext_overflow(ovf), .master_addr_load(ald),
    .master_addr(addr), .reg_addr(radr), .reg_wdata(wdat), .reg_wr(rwr), .reg_rd(rrd),
    .reg_rdata(rdat), .diag_start(start), .octet_ready(ordy), .octet_valid(oval),
    .octet_data(odat), .octet_last(olast), .diag_len(dlen));
  dpsd_sink snk (.clk(clk), .reset(reset), .octet_valid(oval), .octet_data(odat),
    .octet_last(olast), .octet_ready(ordy), .slow(slow), .st1_copy(st1), .st2_copy(st2));
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    rwr <= 1;
    radr <= a;
    wdat <= d;
    @(posedge clk);
    rwr <= 0;
  endtask : wr
  task automatic rd(logic [5:0] a, logic [7:0] e);
    @(posedge clk);
    rrd <= 1;
    radr <= a;
    rq.push_back(e);
    @(posedge clk);
    rrd <= 0;
  endtask : rd
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk("reg_rdata", {1'b0, rq.pop_front()}, {1'b0, rdat});
    rd_d <= rrd;
    if (oval && ordy) chk("octet", oq.pop_front(), {olast, odat});
  end
  task automatic round(int len);
    logic [3:0] r;
    logic [7:0] b[32];
    int k;
    k = len > 26 ? 26 : len;
    r = 4'($random(seed));
    @(posedge clk);
    {lock, prm, nsup, cfg, nrdy, wd, fa, preq, ovf} <= 9'($random(seed));
    {usy, ufz, frz, sync} <= r;
    ald <= 1;
    addr <= 8'($random(seed));
    @(posedge clk);
    {usy, ufz, frz, sync, ald} <= 5'h00;
    // Set beats clear when both pulse together
    sy = r[0] | (sy & ~r[3]);
    fz = r[1] | (fz & ~r[2]);
    wr(6'h1a, 8'(len));
    for (int i = 0; i < 26; i++) begin
      ext[i] = 8'($random(seed));
      wr(6'(i), ext[i]);
    end
    b[0] = {lock, prm, 1'b0, nsup, k != 0, cfg, nrdy, 1'b0};
    b[1] = {2'b00, sy, fz, wd, 1'b0, fa, preq};
    b[2] = {ovf, 7'h00};
    b[3] = addr;
    b[4] = idn[15:8];
    b[5] = idn[7:0];
    for (int i = 0; i < k; i++) b[6 + i] = ext[i];
    chk("diag_len", 9'(6 + k), {3'b000, dlen});
    for (int i = 0; i < 6; i++) rd(6'h20 + 6'(i), b[i]);
    rd(6'h1a, 8'(k));
    rd(6'h1d, 8'h00);
    rd(6'h1b, b[4]);
    rd(6'h1c, b[5]);
    for (int i = 0; i < 6 + k; i++) oq.push_back({i == 5 + k, b[i]});
    @(posedge clk);
    start <= 1;
    @(posedge clk);
    start <= 0;
    repeat (2) @(posedge clk);
    start <= 1;
    @(posedge clk);
    start <= 0;
    for (int t = 0; t < 300 && oq.size() != 0; t++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("octets left", 9'h000, 9'(oq.size()));
    chk("bad response", 9'h000, {8'h00, st1[5]});
    chk("status 1 copy", {1'b0, b[0]}, {1'b0, st1});
    chk("status 2 copy", {1'b0, b[1]}, {1'b0, st2});
  endtask : round
  initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    rd(6'h23, DPSD_ADDR_RESET);
    rd(6'h20, 8'h00);
    for (int i = 0; i < 12; i++) begin
      slow <= i % 2 == 1;
      if (i == 6) begin
        wr(6'h1b, 8'hc3);
        wr(6'h1c, 8'h96);
        idn = 16'hc396;
      end
      round(i == 1 ? 27 : i == 2 ? 26 : i == 3 ? 0 : {$random(seed)} % 32);
    end
    stop_test();
  end
  // Twelve rounds need a few thousand cycles at most
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule : dpsd_builder_bench

/* tb/dpsd_sink.sv */
// Polling master model that accepts the diagnostic octet stream
`timescale 1ns/1ps
module dpsd_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Octet stream
  input wire logic octet_valid,
  input wire logic [7:0] octet_data,
  input wire logic octet_last,
  output logic octet_ready,
  // Control and stored status copy
  input wire logic slow,
  output logic [7:0] st1_copy,
  output logic [7:0] st2_copy
);
  int seed = 4321;
  int cnt = 0;
  initial octet_ready = 1'b0;
  initial st1_copy = 8'h00;
  initial st2_copy = 8'h00;
  // Slow mode stalls at random to stress held octets
  always @(posedge clk) begin
    octet_ready <= !reset && (!slow || 1'($random(seed)));
    if (octet_valid && octet_ready) begin
      cnt <= octet_last ? 0 : cnt + 1;
      // Station answered, so the unreachable mark stays clear
      if (cnt == 0) st1_copy <= {octet_data[7:6], 1'b0, octet_data[4:1], 1'b0};
      if (octet_last && cnt < 5) st1_copy[5] <= 1'b1;
      // Station is active in our parameter set, so the inactive mark stays clear
      if (cnt == 1) st2_copy <= {1'b0, octet_data[6:0]};
    end
  end
endmodule : dpsd_sink
